// File: rtl/csrb_pkg.sv
// Purpose: Constants shared by the converter setup register bank.
// Assumes: Byte-wide register access, one 25 MHz clock.
// Notes: Offsets are the register addresses seen by the power manager.
package csrb_pkg;
	localparam logic [5:0] ADDR_GUARD_CFG_1 = 6'h00;
	localparam logic [5:0] ADDR_SLEW_RAMP_CFG = 6'h03;
	localparam logic [5:0] ADDR_PHASE_FREQ_CFG = 6'h04;
	localparam logic [5:0] ADDR_TURN_ON_DELAY = 6'h05;
	localparam logic [5:0] ADDR_TURN_OFF_DELAY = 6'h06;
	localparam logic [5:0] ADDR_CURRENT_LIMIT = 6'h08;
	localparam logic [5:0] ADDR_DUTY_CYCLE_LIMIT = 6'h09;
	localparam logic [5:0] ADDR_GUARD_CFG_4 = 6'h0A;
	localparam logic [5:0] ADDR_TGT_A_HIGH = 6'h0B;
	localparam logic [5:0] ADDR_TGT_A_LOW = 6'h0C;
	localparam logic [5:0] ADDR_TGT_B_HIGH = 6'h0D;
	localparam logic [5:0] ADDR_TGT_B_LOW = 6'h0E;
	localparam logic [5:0] ADDR_TGT_C_HIGH = 6'h0F;
	localparam logic [5:0] ADDR_TGT_C_LOW = 6'h10;
	localparam logic [5:0] ADDR_LOOP_GAIN_P = 6'h11;
	localparam logic [5:0] ADDR_LOOP_ROLLOFF = 6'h14;
	localparam logic [5:0] ADDR_RUN_ENABLE_STATE = 6'h15;
	localparam logic [5:0] ADDR_HEALTH_FLAGS = 6'h16;
	localparam logic [5:0] ADDR_VOUT_MEAS_HIGH = 6'h17;
	localparam logic [5:0] ADDR_LOAD_CURRENT_MEAS = 6'h18;
	localparam logic [5:0] ADDR_TEMP_MEAS = 6'h19;
	localparam logic [5:0] ADDR_VOUT_MEAS_LOW = 6'h27;
	localparam logic [5:0] SLOT_GAP = 6'h06;
	localparam logic [3:0] SLOT_CURRENT_LIMIT = 4'h8;
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam logic [15:0] TGT_RST = 16'h1900;
	localparam int RUN_EN_BIT = 0;
	localparam int RUN_ON_BIT = 1;
	localparam int RUN_REFUSED_BIT = 2;
	localparam int DROOP_LSB = 0;
	localparam int TGT_CODE_LSB = 4;
	localparam int V_MIN_MV = 700;
	localparam int V_MAX_MV = 2750;
	localparam int V_STEP_UV = 2500;
	localparam logic [11:0] V_MIN_CODE = 12'(V_MIN_MV * 1000 / V_STEP_UV);
	localparam logic [11:0] V_MAX_CODE = 12'(V_MAX_MV * 1000 / V_STEP_UV);
	localparam logic [1:0] SEL_NORM = 2'h0;
	localparam logic [1:0] SEL_LOW = 2'h1;
	localparam logic [1:0] SEL_HIGH = 2'h2;
endpackage

// File: rtl/csrb_wr_if.sv
// Purpose: Register write group passed from the bank to its target slices.
// Assumes: Driven from logic on the bank clock.
// Notes: Clear forces every slice back to its default contents.
`timescale 1ns/100ps
`default_nettype none
interface csrb_wr_if;
	logic wrEn;
	logic [5:0] addr;
	logic [7:0] data;
	logic clear;
	modport bank (output wrEn, output addr, output data, output clear);
	modport target (input wrEn, input addr, input data, input clear);
endinterface
`default_nettype wire

// File: rtl/csrb_sync2.sv
// Purpose: Two flip-flop synchroniser for a level from outside the clock.
// Assumes: The level stays put far longer than two clock periods.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/100ps
`default_nettype none
module csrb_sync2 (
	input wire logic clock,
	input wire logic nrst,
	input wire logic din,
	output logic dout
);
	typedef struct packed {
		logic meta;
		logic held;
	} csrb_sync_t;
	csrb_sync_t s_r;
	csrb_sync_t s_nxt;
	always_comb begin
		s_nxt.meta = din;
		s_nxt.held = s_r.meta;
	end
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
	assign dout = s_r.held;
endmodule
`default_nettype wire

// File: rtl/csrb_vtarget.sv
// Purpose: One 16-bit output voltage target with its high-byte shadow.
// Assumes: High byte is written before low byte.
// Notes: The value only changes on a low-byte write or a clear.
`timescale 1ns/100ps
`default_nettype none
module csrb_vtarget #(
	parameter logic [5:0] HIGH_ADDR = csrb_pkg::ADDR_TGT_A_HIGH,
	parameter logic [5:0] LOW_ADDR = csrb_pkg::ADDR_TGT_A_LOW
) (
	input wire logic clock,
	input wire logic nrst,
	csrb_wr_if.target wr,
	output logic [15:0] value
);
	typedef struct packed {
		logic [7:0] shadow;
		logic [15:0] value;
	} csrb_tgt_t;
	csrb_tgt_t s_r;
	csrb_tgt_t s_nxt;
	always_comb begin
		s_nxt = s_r;
		if (wr.wrEn && wr.addr == HIGH_ADDR) begin
			s_nxt.shadow = wr.data; // RL9
		end
		if (wr.wrEn && wr.addr == LOW_ADDR) begin
			// A lone low write reuses whatever the shadow holds.
			s_nxt.value = {s_r.shadow, wr.data}; // RL9 RL14
		end
		if (wr.clear) begin
			s_nxt.shadow = csrb_pkg::TGT_RST[15:8];
			s_nxt.value = csrb_pkg::TGT_RST; // RL2
		end
	end
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			s_r <= {csrb_pkg::TGT_RST[15:8], csrb_pkg::TGT_RST};
		end else begin
			s_r <= s_nxt;
		end
	end
	assign value = s_r.value;
	chk_high_shadow_only: assert property ( // RL9
		@(posedge clock) disable iff (!nrst)
		(wr.wrEn && wr.addr == HIGH_ADDR && !wr.clear) |=> $stable(value)
	) else $error("High byte write changed the target value.");
	chk_low_commit: assert property ( // RL14
		@(posedge clock) disable iff (!nrst)
		(wr.wrEn && wr.addr == LOW_ADDR && !wr.clear)
		|=> value == {$past(s_r.shadow), $past(wr.data)}
	) else $error("Low byte write did not commit shadow and data.");
endmodule
`default_nettype wire

// File: rtl/csrb_bank.sv
// Purpose: Setup, run, health and monitoring register bank of a converter.
// Assumes: Register accesses arrive as one-cycle strobes on the bus clock.
// Notes: Power loss returns every setup register to its default.
//
// Behaviour
// (RL1) The power manager loads setup addresses 00h to 14h at power-up.
// (RL2) Loss of input power restores all volatile setup registers to default.
// (RL3) Loop filter, frequency and duty limit writes only while output off.
// (RL4) Run 0x15, health 0x16, voltage 0x17/0x27, current 0x18, temp 0x19.
// (RL5) Voltage targets span 0.7 V to 2.75 V in 2.5 mV steps.
// (RL6) Target is a left aligned 12-bit code, one count 2.5 mV.
// (RL7) Three targets: normal, low margin and high margin.
// (RL8) The far party accesses a target high byte before low byte.
// (RL9) High byte goes to a shadow; low byte write commits all 16 bits.
// (RL10) Targets change while running and output follows at once.
// (RL11) All six target bytes are readable and writable.
// (RL12) Droop setting is a 3-bit code selecting one of eight slopes.
// (RL13) On delay, off delay and slew live in three separate registers.
// (RL14) A lone low byte write combines with the current shadow contents.
`timescale 1ns/100ps
`default_nettype none
module csrb_bank (
	input wire logic clock,
	input wire logic nrst,
	input wire logic wrStb,
	input wire logic rdStb,
	input wire logic [5:0] regAddr,
	input wire logic [7:0] wrData,
	output logic [7:0] rdData,
	output logic rdValid,
	input wire logic pwrLost,
	input wire logic outOn,
	input wire logic [1:0] marginSel,
	input wire logic [7:0] healthIn,
	input wire logic [15:0] measVout,
	input wire logic [7:0] measCurrent,
	input wire logic [7:0] measTemp,
	output logic [14:0][7:0] cfgRegs,
	output logic [2:0] droopCode,
	output logic runEnable,
	output logic writeRefused,
	output logic [15:0] vTargetNorm,
	output logic [15:0] vTargetLow,
	output logic [15:0] vTargetHigh,
	output logic [11:0] vSetCode
);
	////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [14:0][7:0] cfg;
		logic runEn;
		logic refused;
		logic [7:0] rdData;
		logic rdValid;
		logic [11:0] vSet;
	} csrb_bank_t;

	csrb_bank_t s_r;
	csrb_bank_t s_nxt;
	logic lostSync;
	logic [7:0] rdMux;
	logic [15:0] tgtSel;
	logic lockedNow;

	csrb_wr_if wrBus ();

	////////////////////////////////////////////////////////////////////////
	// Setup addresses that live in the byte array rather than target slices.
	function automatic logic isCfg(input logic [5:0] a);
		isCfg = (a <= csrb_pkg::ADDR_GUARD_CFG_4) ||
			(a >= csrb_pkg::ADDR_LOOP_GAIN_P &&
			a <= csrb_pkg::ADDR_LOOP_ROLLOFF);
	endfunction

	// The loop filter block sits just past the targets, so close the gap.
	function automatic logic [3:0] cfgSlot(input logic [5:0] a);
		logic [5:0] s;
		s = (a <= csrb_pkg::ADDR_GUARD_CFG_4) ? a : a - csrb_pkg::SLOT_GAP;
		cfgSlot = s[3:0];
	endfunction

	function automatic logic isLocked(input logic [5:0] a);
		isLocked = (a == csrb_pkg::ADDR_PHASE_FREQ_CFG) ||
			(a == csrb_pkg::ADDR_DUTY_CYCLE_LIMIT) ||
			(a >= csrb_pkg::ADDR_LOOP_GAIN_P &&
			a <= csrb_pkg::ADDR_LOOP_ROLLOFF);
	endfunction

	function automatic logic [11:0] clampCode(input logic [11:0] c);
		if (c < csrb_pkg::V_MIN_CODE) begin
			clampCode = csrb_pkg::V_MIN_CODE;
		end else if (c > csrb_pkg::V_MAX_CODE) begin
			clampCode = csrb_pkg::V_MAX_CODE;
		end else begin
			clampCode = c;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Power loss comes from the supply monitor, so it is resynchronised.
	csrb_sync2 lostSyncer (
		.clock(clock),
		.nrst(nrst),
		.din(pwrLost),
		.dout(lostSync)
	);

	assign wrBus.wrEn = wrStb;
	assign wrBus.addr = regAddr;
	assign wrBus.data = wrData;
	assign wrBus.clear = lostSync;

	// Three independent targets share one write group.
	csrb_vtarget #(
		.HIGH_ADDR(csrb_pkg::ADDR_TGT_A_HIGH),
		.LOW_ADDR(csrb_pkg::ADDR_TGT_A_LOW)
	) targetNorm (
		.clock(clock),
		.nrst(nrst),
		.wr(wrBus),
		.value(vTargetNorm)
	); // RL7
	csrb_vtarget #(
		.HIGH_ADDR(csrb_pkg::ADDR_TGT_B_HIGH),
		.LOW_ADDR(csrb_pkg::ADDR_TGT_B_LOW)
	) targetLow (
		.clock(clock),
		.nrst(nrst),
		.wr(wrBus),
		.value(vTargetLow)
	); // RL7
	csrb_vtarget #(
		.HIGH_ADDR(csrb_pkg::ADDR_TGT_C_HIGH),
		.LOW_ADDR(csrb_pkg::ADDR_TGT_C_LOW)
	) targetHigh (
		.clock(clock),
		.nrst(nrst),
		.wr(wrBus),
		.value(vTargetHigh)
	); // RL7

	////////////////////////////////////////////////////////////////////////
	// Read data mux; unmapped addresses answer zero.
	always_comb begin
		rdMux = 8'h00;
		if (isCfg(regAddr)) begin
			rdMux = s_r.cfg[cfgSlot(regAddr)];
		end else begin
			unique case (regAddr)
				csrb_pkg::ADDR_TGT_A_HIGH: rdMux = vTargetNorm[15:8]; // RL11
				csrb_pkg::ADDR_TGT_A_LOW: rdMux = vTargetNorm[7:0]; // RL11
				csrb_pkg::ADDR_TGT_B_HIGH: rdMux = vTargetLow[15:8]; // RL11
				csrb_pkg::ADDR_TGT_B_LOW: rdMux = vTargetLow[7:0]; // RL11
				csrb_pkg::ADDR_TGT_C_HIGH: rdMux = vTargetHigh[15:8]; // RL11
				csrb_pkg::ADDR_TGT_C_LOW: rdMux = vTargetHigh[7:0]; // RL11
				csrb_pkg::ADDR_RUN_ENABLE_STATE: begin
					rdMux[csrb_pkg::RUN_EN_BIT] = s_r.runEn; // RL4
					rdMux[csrb_pkg::RUN_ON_BIT] = outOn;
					rdMux[csrb_pkg::RUN_REFUSED_BIT] = s_r.refused;
				end
				csrb_pkg::ADDR_HEALTH_FLAGS: rdMux = healthIn; // RL4
				csrb_pkg::ADDR_VOUT_MEAS_HIGH: rdMux = measVout[15:8]; // RL4
				csrb_pkg::ADDR_VOUT_MEAS_LOW: rdMux = measVout[7:0]; // RL4
				csrb_pkg::ADDR_LOAD_CURRENT_MEAS: rdMux = measCurrent; // RL4
				csrb_pkg::ADDR_TEMP_MEAS: rdMux = measTemp; // RL4
				default: rdMux = 8'h00;
			endcase
		end
	end

	// The regulation target follows the selected slice without a restart.
	always_comb begin
		unique case (marginSel)
			csrb_pkg::SEL_LOW: tgtSel = vTargetLow;
			csrb_pkg::SEL_HIGH: tgtSel = vTargetHigh;
			default: tgtSel = vTargetNorm;
		endcase
	end

	assign lockedNow = s_r.runEn || outOn;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		s_nxt = s_r;
		s_nxt.rdValid = 1'b0;
		if (wrStb && isCfg(regAddr)) begin
			if (isLocked(regAddr) && lockedNow) begin
				// Changing the filter while switching could upset the loop.
				s_nxt.refused = 1'b1; // RL3
			end else begin
				s_nxt.cfg[cfgSlot(regAddr)] = wrData; // RL13
			end
		end
		if (wrStb && regAddr == csrb_pkg::ADDR_RUN_ENABLE_STATE) begin
			s_nxt.runEn = wrData[csrb_pkg::RUN_EN_BIT];
			if (wrData[csrb_pkg::RUN_REFUSED_BIT]) begin
				s_nxt.refused = 1'b0;
			end
		end
		if (rdStb) begin
			s_nxt.rdData = rdMux;
			s_nxt.rdValid = 1'b1;
		end
		// Left aligned code, clamped to the legal span.
		s_nxt.vSet = clampCode(tgtSel[15:csrb_pkg::TGT_CODE_LSB]); // RL5 RL6 RL10
		if (lostSync) begin
			// No setup or run state survives loss of input; the manager reloads later.
			for (int i = 0; i < 15; i++) begin
				s_nxt.cfg[i] = csrb_pkg::CFG_RST; // RL2 RL1
			end
			s_nxt.runEn = 1'b0;
			s_nxt.refused = 1'b0;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			s_r.cfg <= {15{csrb_pkg::CFG_RST}};
			s_r.runEn <= 1'b0;
			s_r.refused <= 1'b0;
			s_r.rdData <= 8'h00;
			s_r.rdValid <= 1'b0;
			s_r.vSet <= csrb_pkg::V_MIN_CODE;
		end else begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	assign cfgRegs = s_r.cfg;
	assign droopCode = s_r.cfg[csrb_pkg::SLOT_CURRENT_LIMIT]
		[csrb_pkg::DROOP_LSB +: 3]; // RL12
	assign runEnable = s_r.runEn;
	assign writeRefused = s_r.refused;
	assign rdData = s_r.rdData;
	assign rdValid = s_r.rdValid;
	assign vSetCode = s_r.vSet;

	////////////////////////////////////////////////////////////////////////
	chk_lock_refuse: assert property ( // RL3
		@(posedge clock) disable iff (!nrst)
		(wrStb && isCfg(regAddr) && isLocked(regAddr) && lockedNow &&
			!lostSync)
		|=> ($stable(s_r.cfg) && writeRefused)
	) else $error("Locked setup register changed while running.");

	chk_unlocked_write: assert property ( // RL13
		@(posedge clock) disable iff (!nrst)
		(wrStb && regAddr == csrb_pkg::ADDR_TURN_OFF_DELAY && !lostSync)
		|=> cfgRegs[6] == $past(wrData) && $stable(cfgRegs[5])
			&& $stable(cfgRegs[3])
	) else $error("Off delay write did not land alone.");

	chk_power_loss: assert property ( // RL2
		@(posedge clock) disable iff (!nrst)
		lostSync |=> (cfgRegs == {15{csrb_pkg::CFG_RST}} && !runEnable
			&& vTargetNorm == csrb_pkg::TGT_RST)
	) else $error("Power loss did not restore defaults.");

	chk_run_read: assert property ( // RL4
		@(posedge clock) disable iff (!nrst)
		(rdStb && regAddr == csrb_pkg::ADDR_RUN_ENABLE_STATE)
		|=> rdValid && rdData[csrb_pkg::RUN_EN_BIT] == $past(s_r.runEn)
			&& rdData[7:3] == 5'h00
	) else $error("Run register read wrong.");

	chk_meas_low: assert property ( // RL4
		@(posedge clock) disable iff (!nrst)
		(rdStb && regAddr == csrb_pkg::ADDR_VOUT_MEAS_LOW)
		|=> rdValid && rdData == $past(measVout[7:0])
	) else $error("Measured voltage low byte read wrong.");

	chk_target_read: assert property ( // RL11
		@(posedge clock) disable iff (!nrst)
		(rdStb && regAddr == csrb_pkg::ADDR_TGT_B_HIGH)
		|=> rdData == $past(vTargetLow[15:8])
	) else $error("Low margin target high byte read wrong.");

	chk_vset_range: assert property ( // RL5
		@(posedge clock) disable iff (!nrst)
		vSetCode >= csrb_pkg::V_MIN_CODE && vSetCode <= csrb_pkg::V_MAX_CODE
	) else $error("Applied target left the legal span.");

	chk_vset_track: assert property ( // RL10
		@(posedge clock) disable iff (!nrst)
		(marginSel == csrb_pkg::SEL_HIGH &&
			vTargetHigh[15:csrb_pkg::TGT_CODE_LSB] >= csrb_pkg::V_MIN_CODE &&
			vTargetHigh[15:csrb_pkg::TGT_CODE_LSB] <= csrb_pkg::V_MAX_CODE)
		|=> vSetCode == $past(vTargetHigh[15:csrb_pkg::TGT_CODE_LSB])
	) else $error("Applied target did not follow the high margin.");

	chk_unmapped_zero: assert property ( // RL4
		@(posedge clock) disable iff (!nrst)
		(rdStb && regAddr == 6'h20) |=> rdValid && rdData == 8'h00
	) else $error("Unmapped read did not return zero.");

	chk_refused_sticky: assert property ( // RL3
		@(posedge clock) disable iff (!nrst)
		(writeRefused && !lostSync && !(wrStb &&
			regAddr == csrb_pkg::ADDR_RUN_ENABLE_STATE &&
			wrData[csrb_pkg::RUN_REFUSED_BIT]))
		|=> writeRefused
	) else $error("Refused write flag dropped by itself.");

	chk_refused_clear: assert property ( // RL3
		@(posedge clock) disable iff (!nrst)
		(wrStb && regAddr == csrb_pkg::ADDR_RUN_ENABLE_STATE &&
			wrData[csrb_pkg::RUN_REFUSED_BIT])
		|=> !writeRefused
	) else $error("Refused write flag did not clear.");

	chk_unlocked_live: assert property ( // RL3
		@(posedge clock) disable iff (!nrst)
		(wrStb && regAddr == csrb_pkg::ADDR_TURN_ON_DELAY && lockedNow &&
			!lostSync)
		|=> cfgRegs[5] == $past(wrData)
	) else $error("Unlocked setup write refused while running.");

	chk_read_pulse: assert property ( // RL4
		@(posedge clock) disable iff (!nrst)
		!rdStb |=> !rdValid
	) else $error("Read valid stood without a read.");

	chk_run_enable: assert property ( // RL4
		@(posedge clock) disable iff (!nrst)
		(wrStb && regAddr == csrb_pkg::ADDR_RUN_ENABLE_STATE && !lostSync)
		|=> runEnable == $past(wrData[csrb_pkg::RUN_EN_BIT])
	) else $error("Run enable did not take the written bit.");

	chk_droop_code: assert property ( // RL12
		@(posedge clock) disable iff (!nrst)
		(wrStb && regAddr == csrb_pkg::ADDR_CURRENT_LIMIT && !lostSync)
		|=> droopCode == $past(wrData[csrb_pkg::DROOP_LSB +: 3])
	) else $error("Droop code did not follow the limit write.");

	chk_health_read: assert property ( // RL4
		@(posedge clock) disable iff (!nrst)
		(rdStb && regAddr == csrb_pkg::ADDR_HEALTH_FLAGS)
		|=> rdValid && rdData == $past(healthIn)
	) else $error("Health register read wrong.");

	chk_vset_low: assert property ( // RL10
		@(posedge clock) disable iff (!nrst)
		(marginSel == csrb_pkg::SEL_LOW &&
			vTargetLow[15:csrb_pkg::TGT_CODE_LSB] >= csrb_pkg::V_MIN_CODE &&
			vTargetLow[15:csrb_pkg::TGT_CODE_LSB] <= csrb_pkg::V_MAX_CODE)
		|=> vSetCode == $past(vTargetLow[15:csrb_pkg::TGT_CODE_LSB])
	) else $error("Applied target did not follow the low margin.");

	chk_vset_ceiling: assert property ( // RL5
		@(posedge clock) disable iff (!nrst)
		(marginSel == csrb_pkg::SEL_HIGH &&
			vTargetHigh[15:csrb_pkg::TGT_CODE_LSB] > csrb_pkg::V_MAX_CODE)
		|=> vSetCode == csrb_pkg::V_MAX_CODE
	) else $error("Target above the span was not clamped.");

	chk_vset_floor: assert property ( // RL5
		@(posedge clock) disable iff (!nrst)
		(marginSel == csrb_pkg::SEL_HIGH &&
			vTargetHigh[15:csrb_pkg::TGT_CODE_LSB] < csrb_pkg::V_MIN_CODE)
		|=> vSetCode == csrb_pkg::V_MIN_CODE
	) else $error("Target below the span was not clamped.");
endmodule
`default_nettype wire

// File: dv/csrb_mgr_model.sv
// Purpose: Power manager model that drives the bank's register strobes.
// Assumes: Requests change at the falling edge and are taken at the rise.
// Notes: Released address and data lines show inverted values, not zeros.
`timescale 1ns/100ps
`default_nettype none
module csrb_mgr_model (
	input wire logic clock,
	input wire logic [7:0] rdData,
	input wire logic rdValid,
	output logic wrStb,
	output logic rdStb,
	output logic [5:0] regAddr,
	output logic [7:0] wrData
);
	initial begin
		wrStb = 1'b0;
		rdStb = 1'b0;
		regAddr = 6'h3F;
		wrData = 8'h00;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic wrReg(input logic [5:0] a, input logic [7:0] d);
		@(negedge clock);
		wrStb = 1'b1;
		regAddr = a;
		wrData = d;
		@(negedge clock);
		wrStb = 1'b0;
		regAddr = ~a;
		wrData = ~d;
	endtask
	// The high byte always goes first, so the shadow is loaded before use.
	task automatic wrTarget(input logic [5:0] a, input logic [15:0] v);
		wrReg(a, v[15:8]);
		wrReg(a + 6'h01, v[7:0]);
	endtask
	task automatic rdReg(input logic [5:0] a, output logic [7:0] d);
		int n;
		@(negedge clock);
		rdStb = 1'b1;
		regAddr = a;
		@(negedge clock);
		rdStb = 1'b0;
		regAddr = ~a;
		n = 0;
		while (rdValid !== 1'b1 && n < 3) begin
			@(negedge clock);
			n++;
		end
		d = (rdValid === 1'b1) ? rdData : 8'hXX;
	endtask
	// Power-up load walks every setup address in ascending order.
	task automatic loadAll(input logic [7:0] salt);
		for (int a = 0; a <= 20; a++) begin
			wrReg(6'(a), 8'(a * 7) ^ salt);
		end
	endtask
endmodule
`default_nettype wire

// File: dv/converter_setup_register_bank_test.sv
// Purpose: Self-checking bench of the converter setup register bank.
// Assumes: The power manager model is the only bus master.
// Notes: Expected values are rebuilt here from the load pattern.
`timescale 1ns/100ps
`default_nettype none
module converter_setup_register_bank_test;
	logic clock, nrst, pwrLost, outOn, wrStb, rdStb, rdValid;
	logic runEnable, writeRefused;
	logic [1:0] marginSel;
	logic [5:0] regAddr;
	logic [7:0] healthIn, measCurrent, measTemp, wrData, rdData, rd;
	logic [15:0] measVout, vTargetNorm, vTargetLow, vTargetHigh;
	logic [14:0][7:0] cfgRegs;
	logic [2:0] droopCode;
	logic [11:0] vSetCode;
	int nErrors = 0;
	int nTests = 0;
	csrb_bank dut (.clock(clock), .nrst(nrst), .wrStb(wrStb),
		.rdStb(rdStb), .regAddr(regAddr), .wrData(wrData),
		.rdData(rdData), .rdValid(rdValid), .pwrLost(pwrLost),
		.outOn(outOn), .marginSel(marginSel), .healthIn(healthIn),
		.measVout(measVout), .measCurrent(measCurrent),
		.measTemp(measTemp), .cfgRegs(cfgRegs), .droopCode(droopCode),
		.runEnable(runEnable), .writeRefused(writeRefused),
		.vTargetNorm(vTargetNorm), .vTargetLow(vTargetLow),
		.vTargetHigh(vTargetHigh), .vSetCode(vSetCode));
	csrb_mgr_model mgr (.clock(clock), .rdData(rdData),
		.rdValid(rdValid), .wrStb(wrStb), .rdStb(rdStb),
		.regAddr(regAddr), .wrData(wrData));
	////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] pat(input int a);
		return 8'(a * 7) ^ 8'h5A;
	endfunction
	function automatic int idx(input int a);
		return (a <= 10) ? a : a - 6;
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(negedge clock);
	endtask
	task automatic chk(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		nTests++;
		if (seen !== exp) begin
			nErrors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic finishTest;
		$display("comparisons %0d mismatches %0d", nTests, nErrors);
		if (nErrors == 0 && nTests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_defaults;
		chk("norm default", vTargetNorm, 16'h1900);
		chk("code default", 16'(vSetCode), 16'h0118);
		mgr.rdReg(6'h0F, rd);
		chk("tgt c high", 16'(rd), 16'h0019);
		$display("test defaults done");
	endtask
	task automatic t_load;
		mgr.loadAll(8'h5A);
		for (int a = 0; a <= 20; a++) begin
			mgr.rdReg(6'(a), rd);
			chk("readback", 16'(rd), 16'(pat(a)));
			if (a < 11 || a > 16) begin
				chk("cfg", 16'(cfgRegs[idx(a)]), 16'(pat(a)));
			end
		end
		chk("norm", vTargetNorm, {pat(11), pat(12)});
		chk("low", vTargetLow, {pat(13), pat(14)});
		chk("high", vTargetHigh, {pat(15), pat(16)});
		for (int c = 0; c < 8; c++) begin
			mgr.wrReg(6'h08, 8'hF8 | 8'(c));
			chk("droop", 16'(droopCode), 16'(c));
		end
		$display("test load done");
	endtask
	task automatic t_status;
		logic [5:0] ad [6] = '{6'h16, 6'h17, 6'h27, 6'h18, 6'h19, 6'h20};
		logic [7:0] ex [6] = '{8'hA6, 8'hC3, 8'h5B, 8'h4D, 8'h2E, 8'h00};
		healthIn = 8'hA6;
		measVout = 16'hC35B;
		measCurrent = 8'h4D;
		measTemp = 8'h2E;
		outOn = 1'b1;
		for (int i = 0; i < 6; i++) begin
			mgr.rdReg(ad[i], rd);
			chk("status read", 16'(rd), 16'(ex[i]));
		end
		mgr.rdReg(6'h15, rd);
		chk("run read", 16'(rd), 16'h0002);
		outOn = 1'b0;
		$display("test status done");
	endtask
	task automatic t_lock;
		logic [5:0] la [6] = '{6'h04, 6'h09, 6'h11, 6'h12, 6'h13, 6'h14};
		mgr.wrReg(6'h15, 8'h01);
		chk("run enable", 16'(runEnable), 16'h0001);
		foreach (la[i]) begin
			mgr.wrReg(la[i], 8'hEE);
			chk("locked", 16'(cfgRegs[idx(la[i])]), 16'(pat(la[i])));
		end
		chk("refused", 16'(writeRefused), 16'h0001);
		mgr.wrReg(6'h05, 8'hC3);
		chk("live write", 16'(cfgRegs[5]), 16'h00C3);
		mgr.wrTarget(6'h0B, 16'h3200);
		cyc(1);
		chk("live target", 16'(vSetCode), 16'h0320);
		mgr.rdReg(6'h15, rd);
		chk("run read", 16'(rd), 16'h0005);
		mgr.wrReg(6'h15, 8'h04);
		chk("refused clr", 16'(writeRefused), 16'h0000);
		chk("run off", 16'(runEnable), 16'h0000);
		outOn = 1'b1;
		mgr.wrReg(6'h09, 8'h77);
		chk("out on lock", 16'(cfgRegs[9]), 16'(pat(9)));
		outOn = 1'b0;
		mgr.wrReg(6'h09, 8'h77);
		chk("unlocked", 16'(cfgRegs[9]), 16'h0077);
		$display("test lock done");
	endtask
	task automatic t_shadow;
		mgr.wrReg(6'h0D, 8'h2A);
		chk("low held", vTargetLow, {pat(13), pat(14)});
		mgr.wrReg(6'h0E, 8'h50);
		chk("low commit", vTargetLow, 16'h2A50);
		mgr.wrReg(6'h0E, 8'h60);
		chk("lone low", vTargetLow, 16'h2A60);
		mgr.rdReg(6'h0D, rd);
		chk("tgt b high", 16'(rd), 16'h002A);
		marginSel = 2'h1;
		cyc(2);
		chk("sel low", 16'(vSetCode), 16'h02A6);
		marginSel = 2'h2;
		mgr.wrTarget(6'h0F, 16'hFFF0);
		cyc(2);
		chk("clamp max", 16'(vSetCode), 16'h044C);
		mgr.wrTarget(6'h0F, 16'h0000);
		cyc(2);
		chk("clamp min", 16'(vSetCode), 16'h0118);
		mgr.wrTarget(6'h0F, 16'h44C7);
		cyc(2);
		chk("top code", 16'(vSetCode), 16'h044C);
		marginSel = 2'h3;
		cyc(2);
		chk("sel norm", 16'(vSetCode), 16'h0320);
		$display("test shadow done");
	endtask
	task automatic t_pwrloss;
		mgr.wrReg(6'h15, 8'h01);
		pwrLost = 1'b1;
		cyc(5);
		chk("cfg cleared", 16'(|cfgRegs), 16'h0000);
		chk("norm reset", vTargetNorm, 16'h1900);
		chk("high reset", vTargetHigh, 16'h1900);
		chk("run reset", 16'(runEnable), 16'h0000);
		pwrLost = 1'b0;
		cyc(3);
		mgr.rdReg(6'h0B, rd);
		chk("norm high read", 16'(rd), 16'h0019);
		mgr.wrReg(6'h0C, 8'h34);
		chk("shadow reset", vTargetNorm, 16'h1934);
		$display("test power loss done");
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	// The run takes well under two thousand cycles, so this bound is loose.
	initial begin
		repeat (20000) @(posedge clock);
		nErrors++;
		$display("watchdog expired");
		finishTest;
	end
	initial begin
		nrst = 1'b0;
		pwrLost = 1'b0;
		outOn = 1'b0;
		marginSel = 2'h0;
		healthIn = 8'h00;
		measVout = 16'h0000;
		measCurrent = 8'h00;
		measTemp = 8'h00;
		cyc(6);
		nrst = 1'b1;
		t_defaults;
		t_load;
		t_status;
		t_lock;
		t_shadow;
		t_pwrloss;
		finishTest;
	end
endmodule
`default_nettype wire
